/* include/trim_regs_pkg.sv */
// register map, field layout and reset values of the trim and retention bank
package trim_regs_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_BANDGAP = 8'h00;
  localparam logic [7:0] OFF_REGULATOR = 8'h04;
  localparam logic [7:0] OFF_SCRATCH_0 = 8'h08;
  localparam logic [7:0] OFF_SCRATCH_1 = 8'h0c;
  localparam int KEY_LSB = 24;
  localparam int KEY_W = 8;
  localparam int DONE_BIT = 16;
  localparam int TRIM_W = 3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [2:0] TRIM_RESET = 3'h0;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
  localparam int NUM_TRIM = 2;
  localparam int NUM_SCRATCH = 2;
endpackage

/* verilog/trim_slot.sv */
// one key-protected trim register with its fuse-load-done flag
`timescale 1ns/1ps
module trim_slot #(
  parameter int TRIM_W = 3
) (
  // clock and resets
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por,
  // software write of this register
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  // fuse load
  input wire logic i_fuse_valid,
  input wire logic [TRIM_W-1:0] i_fuse_trim,
  // state
  output logic [TRIM_W-1:0] o_trim_value,
  output logic o_fuse_load_done,
  output logic o_unlocked
);
  typedef struct packed {
    logic [TRIM_W-1:0] trim_value;
    logic fuse_load_done;
    logic [1:0] key_stage;
  } slot_t;

  slot_t state;
  slot_t next_state;
  logic [7:0] key;

  assign key = i_wdata[trim_regs_pkg::KEY_LSB +: trim_regs_pkg::KEY_W];

  always_comb
  begin
    next_state = state;
    if (i_wr)
    begin
      // key stage 0 idle, 1 first code seen, 2 pair complete
      if (state.key_stage == 2'd2)
      begin
        next_state.trim_value = i_wdata[TRIM_W-1:0]; // [RULE_01]
        next_state.fuse_load_done = i_wdata[trim_regs_pkg::DONE_BIT]; // [RULE_03]
        next_state.key_stage = 2'd0;
      end
      else if (state.key_stage == 2'd0 && key == trim_regs_pkg::KEY_FIRST)
        next_state.key_stage = 2'd1; // [RULE_01]
      else if (state.key_stage == 2'd1 && key == trim_regs_pkg::KEY_SECOND)
        next_state.key_stage = 2'd2; // [RULE_01]
      else
        next_state.key_stage = 2'd0; // [RULE_08]
    end
    // fuse load only while the flag is clear; the load sets it
    if (i_fuse_valid && !state.fuse_load_done)
    begin
      next_state.trim_value = i_fuse_trim; // [RULE_03]
      next_state.fuse_load_done = 1'b1; // [RULE_02]
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_por)
      state <= '{trim_value: trim_regs_pkg::TRIM_RESET, fuse_load_done: 1'b0, key_stage: 2'd0};
    else if (i_rst)
      state.key_stage <= 2'd0;
    else
      state <= next_state;
  end

  assign o_trim_value = state.trim_value;
  assign o_fuse_load_done = state.fuse_load_done;
  assign o_unlocked = (state.key_stage == 2'd2);
endmodule

/* verilog/trim_and_retention_regs.sv */
// apb register bank: bandgap and regulator trim plus two retained scratch words
// What this block does
// RULE_01 - calibration writes apply only after key 0x55 then 0xaa writes
// RULE_02 - fuse_load_done sets once fuses load the trim value
// RULE_03 - while fuse_load_done is set, fuse loads are blocked; por or clearing resumes
// RULE_04 - bandgap_trim holds a read/write trim value driving the bandgap
// RULE_05 - regulator_trim holds a read/write trim value driving the regulator
// RULE_06 - two 32-bit retained scratch registers, cleared only by power-on
// RULE_07 - non power-on resets leave the scratch registers unchanged
// RULE_08 - unlocked-less write changes nothing and restarts the key sequence
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module trim_and_retention_regs #(
  parameter int TRIM_W = trim_regs_pkg::TRIM_W
) (
  // clock and resets
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // fuse loader
  input wire logic i_bandgap_fuse_valid,
  input wire logic [TRIM_W-1:0] i_bandgap_fuse_trim,
  input wire logic i_regulator_fuse_valid,
  input wire logic [TRIM_W-1:0] i_regulator_fuse_trim,
  // trim outputs to the analog
  output logic [TRIM_W-1:0] o_bandgap_trim,
  output logic [TRIM_W-1:0] o_regulator_trim
);
  typedef struct packed {
    logic [31:0] scratch_0;
    logic [31:0] scratch_1;
    logic [31:0] rdata;
  } bank_t;

  bank_t state;
  bank_t next_state;
  logic access;
  logic wr;
  logic hit;
  logic wr_bandgap;
  logic wr_regulator;
  logic bg_done;
  logic rg_done;
  logic bg_unl;
  logic rg_unl;

  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  assign wr_bandgap = wr && i_paddr == trim_regs_pkg::OFF_BANDGAP;
  assign wr_regulator = wr && i_paddr == trim_regs_pkg::OFF_REGULATOR;
  assign hit = i_paddr == trim_regs_pkg::OFF_BANDGAP || i_paddr == trim_regs_pkg::OFF_REGULATOR
    || i_paddr == trim_regs_pkg::OFF_SCRATCH_0 || i_paddr == trim_regs_pkg::OFF_SCRATCH_1;

  trim_slot #(.TRIM_W(TRIM_W)) bandgap_slot (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_por(i_por),
    .i_wr(wr_bandgap),
    .i_wdata(i_pwdata),
    .i_fuse_valid(i_bandgap_fuse_valid),
    .i_fuse_trim(i_bandgap_fuse_trim),
    .o_trim_value(o_bandgap_trim), // [RULE_04]
    .o_fuse_load_done(bg_done),
    .o_unlocked(bg_unl)
  );

  trim_slot #(.TRIM_W(TRIM_W)) regulator_slot (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_por(i_por),
    .i_wr(wr_regulator),
    .i_wdata(i_pwdata),
    .i_fuse_valid(i_regulator_fuse_valid),
    .i_fuse_trim(i_regulator_fuse_trim),
    .o_trim_value(o_regulator_trim), // [RULE_05]
    .o_fuse_load_done(rg_done),
    .o_unlocked(rg_unl)
  );

  always_comb
  begin
    next_state = state;
    if (wr && i_paddr == trim_regs_pkg::OFF_SCRATCH_0)
      next_state.scratch_0 = i_pwdata; // [RULE_06]
    if (wr && i_paddr == trim_regs_pkg::OFF_SCRATCH_1)
      next_state.scratch_1 = i_pwdata; // [RULE_06]
    // read data is captured in the setup cycle so it is registered at access
    next_state.rdata = 32'h0000_0000;
    if (i_psel && !i_penable && !i_pwrite)
    begin
      unique case (i_paddr)
        trim_regs_pkg::OFF_BANDGAP:
          next_state.rdata = {15'h0000, bg_done, {(16 - TRIM_W){1'b0}}, o_bandgap_trim};
        trim_regs_pkg::OFF_REGULATOR:
          next_state.rdata = {15'h0000, rg_done, {(16 - TRIM_W){1'b0}}, o_regulator_trim};
        trim_regs_pkg::OFF_SCRATCH_0:
          next_state.rdata = state.scratch_0;
        trim_regs_pkg::OFF_SCRATCH_1:
          next_state.rdata = state.scratch_1;
        default:
          next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_por)
      state <= '{scratch_0: trim_regs_pkg::SCRATCH_RESET,
                 scratch_1: trim_regs_pkg::SCRATCH_RESET,
                 rdata: 32'h0000_0000};
    else if (i_rst)
      state.rdata <= 32'h0000_0000; // [RULE_07]
    else
      state <= next_state;
  end

  assign o_prdata = state.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;
endmodule

/* dv/trim_regs_sva.sv */
// assertions for the trim and retention register bank
`timescale 1ns/1ps
module trim_regs_sva #(
  parameter int TRIM_W = 3
) (
  input wire logic i_clock,
  input wire logic i_por,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_bandgap_fuse_valid,
  input wire logic [TRIM_W-1:0] o_bandgap_trim,
  input wire logic [TRIM_W-1:0] o_regulator_trim
);
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite;
  wire rda = acc & !i_pwrite;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_por);
  chk_err_unmapped: assert property (acc && i_paddr > 8'h0c |-> o_pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && i_paddr[7:4] == 0 && i_paddr[1:0] == 0 |-> !o_pslverr)
    else $error("error on mapped access");
  chk_idle_zero: assert property (!i_psel |-> o_prdata == 0)
    else $error("read data while idle");
  chk_err_rdzero: assert property (rda && i_paddr > 8'h0c |-> o_prdata == 0)
    else $error("data from unmapped read");
  chk_rd_bandgap: assert property (rda && i_paddr == 0 |-> o_prdata[2:0] == o_bandgap_trim)
    else $error("bandgap read mismatch");
  chk_rd_regulator: assert property (rda && i_paddr == 4 |-> o_prdata[2:0] == o_regulator_trim)
    else $error("regulator read mismatch");
  chk_trim_cause: assert property (!$stable(o_bandgap_trim) |-> $past(i_bandgap_fuse_valid | (wr && i_paddr == 8'h00)))
    else $error("trim changed without cause");
  chk_fuse_block: assert property (i_bandgap_fuse_valid ##1 (i_bandgap_fuse_valid && !wr)
    |=> $stable(o_bandgap_trim))
    else $error("second fuse load not blocked");
  cover property (wr && i_paddr == 0);
  cover property (acc && o_pslverr);
  cover property (i_bandgap_fuse_valid [*2]);
endmodule
bind trim_and_retention_regs trim_regs_sva #(.TRIM_W(TRIM_W)) u_sva (.i_clock(i_clock),
  .i_por(i_por), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_bandgap_fuse_valid(i_bandgap_fuse_valid), .o_bandgap_trim(o_bandgap_trim),
  .o_regulator_trim(o_regulator_trim));

/* dv/trim_and_retention_regs_tb_top.sv */
// self-checking bench for the trim and retention register bank
`timescale 1ns/1ps
module trim_and_retention_regs_tb_top;
  logic i_clock = 0, rst = 1, por = 1, sel = 0, en = 0, wr = 0, fv = 0, rdy, er, se;
  logic [7:0] pa = 0;
  logic [31:0] pw = 0, rd, prd;
  logic [2:0] ft = 0, bo, ro;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  trim_and_retention_regs u_dut (.i_clock(i_clock), .i_rst(rst), .i_por(por), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(pa), .i_pwdata(pw), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(er), .i_bandgap_fuse_valid(fv), .i_bandgap_fuse_trim(ft),
    .i_regulator_fuse_valid(fv), .i_regulator_fuse_trim(ft), .o_bandgap_trim(bo),
    .o_regulator_trim(ro));
  initial forever #2 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    sel <= 1;
    wr <= w;
    pa <= a;
    pw <= d;
    @(posedge i_clock);
    en <= 1;
    do @(posedge i_clock); while (rdy !== 1'b1);
    rd = prd;
    se = er;
    sel <= 0;
    en <= 0;
  endtask
  task wkey(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, 32'h5500_0000);
    apb(1, a, 32'haa00_0000);
    apb(1, a, d);
  endtask
  task fuse(input logic [2:0] v);
    @(posedge i_clock);
    fv <= 1;
    ft <= v;
    @(posedge i_clock);
    ft <= ~v;
    @(posedge i_clock);
    fv <= 0;
    apb(0, 8'h00, 0);
  endtask
  task t_lock;
    for (int a = 0; a < 8; a += 4)
    begin
      apb(1, a[7:0], 32'h5);
      apb(0, a[7:0], 0);
      chk(0, rd);
      wkey(a[7:0], 32'h5);
      apb(0, a[7:0], 0);
      chk(5, rd);
      apb(1, a[7:0], 32'h5500_0000);
      apb(1, a[7:0], 32'h1200_0000);
      apb(1, a[7:0], 32'haa00_0000);
      apb(1, a[7:0], 32'h3);
      chk(5, a[2] ? ro : bo);
    end
    $display("t_lock done");
  endtask
  task t_fuse;
    fuse(3'h6);
    chk(32'h0001_0006, rd);
    chk(6, ro);
    fuse(3'h1);
    chk(32'h0001_0006, rd);
    wkey(0, 32'h2);
    fuse(3'h1);
    chk(32'h0001_0001, rd);
    $display("t_fuse done");
  endtask
  task t_ret;
    apb(1, 8'h08, 32'hdead_beef);
    apb(1, 8'h0c, 32'h1234_5678);
    rst <= 1;
    repeat (2) @(posedge i_clock);
    rst <= 0;
    apb(0, 8'h08, 0);
    chk(32'hdead_beef, rd);
    apb(0, 8'h0c, 0);
    chk(32'h1234_5678, rd);
    por <= 1;
    repeat (3) @(posedge i_clock);
    por <= 0;
    apb(0, 8'h0c, 0);
    chk(0, rd);
    apb(1, 8'h10, 32'h1);
    chk(1, se);
    $display("t_ret done");
  endtask
  initial
  begin
    repeat (3) @(posedge i_clock);
    rst <= 0;
    por <= 0;
    t_lock;
    t_fuse;
    t_ret;
    report_and_stop;
  end
endmodule
